//--- design/cmd_port_if.sv
// Interface joining processor end and module end of the command port
`timescale 1ns/10ps
interface cmd_port_if;
   cmd_port_pkg::word_type out_words [cmd_port_pkg::NUM_WORDS];
   cmd_port_pkg::word_type in_words [cmd_port_pkg::NUM_WORDS];
   modport module_end (input out_words, output in_words);
   modport cpu_end (output out_words, input in_words);
endinterface

//--- design/cmd_port_pkg.sv
// Package with shared constants and types for the handshake command port
package cmd_port_pkg;
   localparam int WORD_W = 16;
   localparam int NUM_WORDS = 8;
   localparam int HS_BIT = 15;
   localparam int AXIS_A_BIT = 13;
   localparam int AXIS_B_BIT = 12;
   localparam int CODE_LSB = 0;
   localparam int CODE_MSB = 7;
   localparam int MAX_WRITE_PER_XCHG = 7;
   localparam int MAX_READ_PER_XCHG = 4;
   localparam int READ_FIRST_WORD = 4;
   localparam int CMD_W = 8;
   localparam int CNT_W = 8;
   localparam logic [CMD_W-1:0] CMD_FORMAT = 8'hF0;
   localparam logic [CMD_W-1:0] CMD_INIT = 8'hF1;
   localparam logic [CMD_W-1:0] CMD_WR_ALL = 8'hF2;
   localparam logic [CMD_W-1:0] CMD_WR_COMMON = 8'hF3;
   localparam logic [CMD_W-1:0] CMD_WR_PROF = 8'hF4;
   localparam logic [CMD_W-1:0] CMD_WR_PROF2 = 8'hF5;
   localparam logic [CMD_W-1:0] CMD_WR_SEQ = 8'hF6;
   localparam logic [CMD_W-1:0] CMD_WR_SYS = 8'hF7;
   localparam logic [CMD_W-1:0] CMD_WR_AXIS = 8'hF8;
   localparam logic [CMD_W-1:0] CMD_READ_LO = 8'hB0;
   localparam logic [CMD_W-1:0] CMD_READ_HI = 8'hE8;
   // Store operation selects, binary encoded in declaration order
   typedef enum logic [3:0] {
      STORE_NONE, STORE_FORMAT, STORE_INIT, STORE_ALL, STORE_COMMON,
      STORE_PROF, STORE_SEQ, STORE_SYS, STORE_AXIS
   } store_op_type;
   typedef logic [WORD_W-1:0] word_type;
endpackage

//--- design/cpu_cmd_port.sv
// Processor end: loads control words, raises handshake last, waits ack
`timescale 1ns/10ps
module cpu_cmd_port
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // Link to module
   cmd_port_if.cpu_end link,
   // Command request from the application
   input wire logic req_i,
   input wire logic [cmd_port_pkg::CMD_W-1:0] code_i,
   input wire logic axis_a_i,
   input wire logic axis_b_i,
   input wire cmd_port_pkg::word_type data_i [cmd_port_pkg::MAX_WRITE_PER_XCHG],
   output logic ready_o,
   // Completion and returned words
   output logic done_o,
   output cmd_port_pkg::word_type resp_o [cmd_port_pkg::NUM_WORDS]
);
   localparam int N = cmd_port_pkg::NUM_WORDS;
   localparam int HS = cmd_port_pkg::HS_BIT;

   // ----------------------------------------------------------------
   // Synchronise module words
   // ----------------------------------------------------------------
   cmd_port_pkg::word_type in_meta_r [N];
   cmd_port_pkg::word_type in_sync_r [N];
   always_ff @(posedge sys_clk_i)
   begin
      for (int i = 0; i < N; i++)
      begin
         in_meta_r[i] <= link.in_words[i];
         in_sync_r[i] <= in_meta_r[i];
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   typedef enum {IDLE, LOAD, RAISE, WAIT_ACK, WAIT_DROP} cpu_state_type;
   cpu_state_type state_r;
   cmd_port_pkg::word_type out_r [N];
   logic ack;
   assign ack = in_sync_r[0][HS];
   assign ready_o = (state_r == IDLE);

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         state_r <= IDLE;
         done_o <= 1'b0;
         for (int i = 0; i < N; i++)
         begin
            out_r[i] <= '0;
            resp_o[i] <= '0;
         end
      end
      else
      begin
         done_o <= 1'b0;
         case (state_r)
            IDLE:
               if (req_i)
               begin
                  // Data and word 1 loaded in the same cycle, word 1 without flag
                  for (int i = 1; i < N; i++)
                     out_r[i] <= data_i[i-1];
                  out_r[0] <= '0;
                  out_r[0][cmd_port_pkg::AXIS_A_BIT] <= axis_a_i;
                  out_r[0][cmd_port_pkg::AXIS_B_BIT] <= axis_b_i;
                  out_r[0][cmd_port_pkg::CODE_MSB:cmd_port_pkg::CODE_LSB] <= code_i;
                  state_r <= LOAD;
               end
            LOAD:
               // Extra cycle so the module's synchroniser sees data before flag
               state_r <= RAISE;
            RAISE:
            begin
               out_r[0][HS] <= 1'b1;
               state_r <= WAIT_ACK;
            end
            WAIT_ACK:
               if (ack)
               begin
                  for (int i = 0; i < N; i++)
                     resp_o[i] <= in_sync_r[i];
                  out_r[0][HS] <= 1'b0;
                  state_r <= WAIT_DROP;
               end
            WAIT_DROP:
               if (!ack)
               begin
                  done_o <= 1'b1;
                  state_r <= IDLE;
               end
            default:
               state_r <= IDLE;
         endcase
      end
   end

   always_comb
   begin
      for (int i = 0; i < N; i++)
         link.out_words[i] = out_r[i];
   end
endmodule // cpu_cmd_port

//--- design/motion_cmd_port.sv
// Module end: decodes handshaked commands, drives status words and store ops
// Operation
// - F0 formats store, F1 restores defaults
// - F2 writes everything into store
// - F3 writes common parameters, axis selectable
// - F4 and F5 write all profiles
// - F6 writes sequence table, axis selectable
// - F7 writes system parameters
// - F8 writes axis operation data, axis selectable
// - Power loss mid-write loses store data
// - Eight input and eight output words
// - Bit 15 of word 1 is handshake
// - Processor loads data, axis bits 13/12
// - Command code in output bits 0-7
// - Processor sets handshake flag last
// - Module acknowledges by setting input flag
// - Processor clears flag after acknowledge
// - Writes over 7 words use several exchanges
// - Reads over 4 words use several exchanges
// - Hold read data while flag set
// - Resume status updates after flag clears
// - Next read set on each flag rise
`timescale 1ns/10ps
module motion_cmd_port
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // Link to processor
   cmd_port_if.module_end link,
   // Live status words from the motion core
   input wire cmd_port_pkg::word_type status_i [cmd_port_pkg::NUM_WORDS],
   // Parameter words for reads, addressed by set index
   input wire cmd_port_pkg::word_type param_i [cmd_port_pkg::MAX_READ_PER_XCHG],
   output logic [cmd_port_pkg::CNT_W-1:0] param_set_o,
   // Store operation request to the parameter store
   output logic store_start_o,
   output cmd_port_pkg::store_op_type store_op_o,
   output logic store_axis_a_o,
   output logic store_axis_b_o,
   output cmd_port_pkg::word_type store_data_o,
   input wire logic store_busy_i,
   // Command word delivered to the motion core for other commands
   output logic cmd_valid_o,
   output cmd_port_pkg::word_type cmd_words_o [cmd_port_pkg::NUM_WORDS]
);
   localparam int N = cmd_port_pkg::NUM_WORDS;
   localparam int HS = cmd_port_pkg::HS_BIT;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Words come from the processor's scan, so they are treated as foreign
   cmd_port_pkg::word_type out_meta_r [N];
   cmd_port_pkg::word_type out_sync_r [N];
   logic hs_prev_r;
   always_ff @(posedge sys_clk_i)
   begin
      for (int i = 0; i < N; i++)
      begin
         out_meta_r[i] <= link.out_words[i];
         out_sync_r[i] <= out_meta_r[i];
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         hs_prev_r <= 1'b0;
      else
         hs_prev_r <= out_sync_r[0][HS];
   end

   logic hs_now;
   logic hs_rise;
   logic [cmd_port_pkg::CMD_W-1:0] code;
   logic is_read;
   assign hs_now = out_sync_r[0][HS];
   assign hs_rise = hs_now && !hs_prev_r;
   assign code = out_sync_r[0][cmd_port_pkg::CODE_MSB:cmd_port_pkg::CODE_LSB];
   assign is_read = (code >= cmd_port_pkg::CMD_READ_LO) && (code <= cmd_port_pkg::CMD_READ_HI);

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   cmd_port_pkg::store_op_type op_nxt;
   always_comb
   begin
      op_nxt = cmd_port_pkg::STORE_NONE;
      case (code)
         cmd_port_pkg::CMD_FORMAT: op_nxt = cmd_port_pkg::STORE_FORMAT;
         cmd_port_pkg::CMD_INIT: op_nxt = cmd_port_pkg::STORE_INIT;
         cmd_port_pkg::CMD_WR_ALL: op_nxt = cmd_port_pkg::STORE_ALL;
         cmd_port_pkg::CMD_WR_COMMON: op_nxt = cmd_port_pkg::STORE_COMMON;
         cmd_port_pkg::CMD_WR_PROF: op_nxt = cmd_port_pkg::STORE_PROF;
         cmd_port_pkg::CMD_WR_PROF2: op_nxt = cmd_port_pkg::STORE_PROF;
         cmd_port_pkg::CMD_WR_SEQ: op_nxt = cmd_port_pkg::STORE_SEQ;
         cmd_port_pkg::CMD_WR_SYS: op_nxt = cmd_port_pkg::STORE_SYS;
         cmd_port_pkg::CMD_WR_AXIS: op_nxt = cmd_port_pkg::STORE_AXIS;
         default: op_nxt = cmd_port_pkg::STORE_NONE;
      endcase
   end

   // ----------------------------------------------------------------
   // Exchange state
   // ----------------------------------------------------------------
   typedef enum {IDLE, ACK} xchg_type;
   xchg_type state_r;
   logic ack_r;
   logic in_read_r;
   logic [cmd_port_pkg::CNT_W-1:0] set_r;
   logic [cmd_port_pkg::CMD_W-1:0] read_code_r;

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         state_r <= IDLE;
         ack_r <= 1'b0;
      end
      else
      begin
         case (state_r)
            IDLE:
               // Store ops wait for the store to be free, flag rise is remembered
               if (hs_rise || (hs_now && !ack_r))
               begin
                  if (!(op_nxt != cmd_port_pkg::STORE_NONE && store_busy_i))
                  begin
                     ack_r <= 1'b1;
                     state_r <= ACK;
                  end
               end
            ACK:
               if (!hs_now)
               begin
                  ack_r <= 1'b0;
                  state_r <= IDLE;
               end
            default:
               state_r <= IDLE;
         endcase
      end
   end

   logic accept;
   assign accept = (state_r == IDLE) && hs_now && !ack_r
      && !(op_nxt != cmd_port_pkg::STORE_NONE && store_busy_i);

   // Read session: the set index names the set that the next read shows,
   // because the parameter words are taken in the same cycle as the accept.
   // A new session clears it while its code is staged ahead of the flag.
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         in_read_r <= 1'b0;
         set_r <= '0;
         read_code_r <= '0;
      end
      else if (accept && is_read)
      begin
         in_read_r <= 1'b1;
         read_code_r <= code;
         set_r <= set_r + 8'h01;
      end
      else if (accept)
         in_read_r <= 1'b0;
      else if (state_r == IDLE && !hs_now && !(in_read_r && is_read && code == read_code_r))
         set_r <= '0;
   end
   assign param_set_o = set_r;

   // ----------------------------------------------------------------
   // Store request and command hand-off
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         store_start_o <= 1'b0;
         store_op_o <= cmd_port_pkg::STORE_NONE;
         store_axis_a_o <= 1'b0;
         store_axis_b_o <= 1'b0;
         store_data_o <= '0;
      end
      else
      begin
         store_start_o <= accept && (op_nxt != cmd_port_pkg::STORE_NONE);
         if (accept && op_nxt != cmd_port_pkg::STORE_NONE)
         begin
            store_op_o <= op_nxt;
            store_axis_a_o <= out_sync_r[0][cmd_port_pkg::AXIS_A_BIT];
            store_axis_b_o <= out_sync_r[0][cmd_port_pkg::AXIS_B_BIT];
            // Only F5 carries a data word; others leave it zero
            store_data_o <= (code == cmd_port_pkg::CMD_WR_PROF2) ? out_sync_r[1] : '0;
         end
      end
   end
   // Power loss during a store write is not recoverable here; the store
   // itself must treat an interrupted write as lost content

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         cmd_valid_o <= 1'b0;
         for (int i = 0; i < N; i++)
            cmd_words_o[i] <= '0;
      end
      else
      begin
         // Each exchange passes up to seven data words; longer writes
         // arrive as several pulses
         cmd_valid_o <= accept && (op_nxt == cmd_port_pkg::STORE_NONE);
         if (accept)
            for (int i = 0; i < N; i++)
               cmd_words_o[i] <= out_sync_r[i];
      end
   end

   // ----------------------------------------------------------------
   // Input status words
   // ----------------------------------------------------------------
   cmd_port_pkg::word_type in_r [N];
   logic hold;
   assign hold = in_read_r && hs_now;
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         for (int i = 0; i < N; i++)
            in_r[i] <= '0;
      else
      begin
         for (int i = 0; i < N; i++)
         begin
            if (accept && is_read && i >= cmd_port_pkg::READ_FIRST_WORD)
               in_r[i] <= param_i[i - cmd_port_pkg::READ_FIRST_WORD];
            else if (!hold && !(accept && is_read))
               in_r[i] <= status_i[i];
         end
         in_r[0][HS] <= 1'b0;
      end
   end

   always_comb
   begin
      for (int i = 0; i < N; i++)
         link.in_words[i] = in_r[i];
      link.in_words[0][HS] = ack_r;
   end
endmodule // motion_cmd_port

//--- tb/cmd_port_properties.sv
// Concurrent checks on the handshake words between the processor end and the module end
`timescale 1ns/10ps
module cmd_port_properties
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // Link words
   input wire cmd_port_pkg::word_type out_words [cmd_port_pkg::NUM_WORDS],
   input wire cmd_port_pkg::word_type in_words [cmd_port_pkg::NUM_WORDS]
);
   logic flag;
   logic ack;
   logic is_read;
   assign flag = out_words[0][cmd_port_pkg::HS_BIT];
   assign ack = in_words[0][cmd_port_pkg::HS_BIT];
   assign is_read = (out_words[0][7:0] >= cmd_port_pkg::CMD_READ_LO) &&
      (out_words[0][7:0] <= cmd_port_pkg::CMD_READ_HI);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);
   // The flag crosses two synchroniser stages, so no answer may come sooner
   sequence s_ack_wait;
      !ack [*2] ##[1:28] ack;
   endsequence
   sequence s_read_held;
      flag && ack && is_read ##1 flag && ack;
   endsequence
   AST_ACK_AFTER_RISE: assert property ($rose(flag) |-> s_ack_wait)
      else $error("acknowledge missing or early after flag rise");
   AST_ACK_NEEDS_FLAG: assert property ($rose(ack) |-> flag && $past(flag, 2))
      else $error("acknowledge raised without a standing flag");
   AST_ACK_STANDS: assert property (ack && flag |=> ack)
      else $error("acknowledge dropped while flag still set");
   AST_ACK_DROP: assert property ($fell(flag) |-> ##[1:4] !ack)
      else $error("acknowledge not cleared after flag drop");
   AST_HS_LAST: assert property ($rose(flag) |-> $stable(out_words[0][13:0]) &&
      $stable(out_words[1]))
      else $error("command words changed with the flag rise");
   AST_CPU_HOLDS: assert property (flag && !ack |=> flag)
      else $error("flag dropped before acknowledge");
   AST_CPU_CLEARS: assert property ($rose(ack) |-> ##[1:4] !flag)
      else $error("flag not cleared after acknowledge");
   AST_NO_OVERLAP: assert property ($rose(flag) |-> !ack)
      else $error("new flag raised while acknowledge stands");
   AST_READ_HOLD: assert property (s_read_held |-> $stable(in_words[4]) &&
      $stable(in_words[5]) && $stable(in_words[6]) && $stable(in_words[7]))
      else $error("read words changed while flag set");
endmodule // cmd_port_properties

//--- tb/tb_top.sv
// Self-checking bench joining the processor end and the module end
`timescale 1ns/10ps
module tb_top;
   typedef struct {logic [7:0] code; logic ax_a; logic ax_b; cmd_port_pkg::store_op_type op;} row_type;
   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic req_i = 1'b0;
   logic [7:0] code_i = 8'h00;
   logic axis_a_i = 1'b0;
   logic axis_b_i = 1'b0;
   logic store_busy_i = 1'b0;
   cmd_port_pkg::word_type data_i [cmd_port_pkg::MAX_WRITE_PER_XCHG];
   cmd_port_pkg::word_type status_i [cmd_port_pkg::NUM_WORDS];
   cmd_port_pkg::word_type param_i [cmd_port_pkg::MAX_READ_PER_XCHG];
   cmd_port_pkg::word_type cmd_words_o [cmd_port_pkg::NUM_WORDS];
   cmd_port_pkg::word_type resp_o [cmd_port_pkg::NUM_WORDS];
   cmd_port_pkg::word_type store_data_o;
   cmd_port_pkg::word_type got_data;
   cmd_port_pkg::store_op_type store_op_o;
   cmd_port_pkg::store_op_type got_op;
   logic [7:0] param_set_o;
   logic [7:0] first_set;
   logic store_start_o;
   logic store_axis_a_o;
   logic store_axis_b_o;
   logic cmd_valid_o;
   logic ready_o;
   logic done_o;
   logic got_a;
   logic got_b;
   int fail_count = 0;
   int checked = 0;
   int starts = 0;
   int valids = 0;
   int cycles = 0;
   int s0;
   int v0;
   row_type rows [11];
   always #10 sys_clk_i = ~sys_clk_i;
   // Parameter set index lands in the upper byte so later sets can be told apart
   always_comb
   begin
      for (int k = 0; k < cmd_port_pkg::MAX_READ_PER_XCHG; k++)
         param_i[k] = {param_set_o, 8'(k)};
   end
   cmd_port_if i_cmd_port_if ();
   motion_cmd_port i_motion_cmd_port (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .link(i_cmd_port_if), .status_i(status_i), .param_i(param_i),
      .param_set_o(param_set_o), .store_start_o(store_start_o), .store_op_o(store_op_o),
      .store_axis_a_o(store_axis_a_o), .store_axis_b_o(store_axis_b_o),
      .store_data_o(store_data_o), .store_busy_i(store_busy_i), .cmd_valid_o(cmd_valid_o),
      .cmd_words_o(cmd_words_o));
   cpu_cmd_port i_cpu_cmd_port (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .link(i_cmd_port_if), .req_i(req_i), .code_i(code_i), .axis_a_i(axis_a_i),
      .axis_b_i(axis_b_i), .data_i(data_i), .ready_o(ready_o), .done_o(done_o),
      .resp_o(resp_o));
   cmd_port_properties i_cmd_port_properties (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .out_words(i_cmd_port_if.out_words), .in_words(i_cmd_port_if.in_words));
   // ----------------------------------------
   // Monitor and timeout
   // ----------------------------------------
   always @(posedge sys_clk_i)
   begin
      cycles <= cycles + 1;
      if (store_start_o === 1'b1)
      begin
         starts <= starts + 1;
         got_op <= store_op_o;
         got_a <= store_axis_a_o;
         got_b <= store_axis_b_o;
         got_data <= store_data_o;
      end
      if (cmd_valid_o === 1'b1)
         valids <= valids + 1;
      if (cycles == 20000)
      begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask
   // Waits are bounded so a stuck handshake reports instead of hanging
   task automatic issue(input logic [7:0] c, input logic a, input logic b);
      int n;
      n = 0;
      while (ready_o !== 1'b1 && n < 200)
      begin
         @(posedge sys_clk_i);
         #2;
         n++;
      end
      req_i = 1'b1;
      code_i = c;
      axis_a_i = a;
      axis_b_i = b;
      @(posedge sys_clk_i);
      #2;
      req_i = 1'b0;
      n = 0;
      while (done_o !== 1'b1 && n < 200)
      begin
         @(posedge sys_clk_i);
         #2;
         n++;
      end
      chk("done", 16'h0001, {15'h0000, done_o});
   endtask
   task automatic wrap_up;
      if (fail_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      for (int k = 0; k < cmd_port_pkg::NUM_WORDS; k++)
         status_i[k] = 16'h1100 + 16'(k);
      for (int k = 0; k < cmd_port_pkg::MAX_WRITE_PER_XCHG; k++)
         data_i[k] = 16'hD000 + 16'(k);
      rows = '{'{8'hF0, 1'b0, 1'b0, cmd_port_pkg::STORE_FORMAT},
         '{8'hF1, 1'b0, 1'b0, cmd_port_pkg::STORE_INIT},
         '{8'hF2, 1'b0, 1'b0, cmd_port_pkg::STORE_ALL},
         '{8'hF3, 1'b1, 1'b0, cmd_port_pkg::STORE_COMMON},
         '{8'hF4, 1'b0, 1'b0, cmd_port_pkg::STORE_PROF},
         '{8'hF5, 1'b0, 1'b0, cmd_port_pkg::STORE_PROF},
         '{8'hF6, 1'b0, 1'b1, cmd_port_pkg::STORE_SEQ},
         '{8'hF7, 1'b0, 1'b0, cmd_port_pkg::STORE_SYS},
         '{8'hF8, 1'b1, 1'b1, cmd_port_pkg::STORE_AXIS},
         '{8'h10, 1'b1, 1'b0, cmd_port_pkg::STORE_NONE},
         '{8'h2F, 1'b1, 1'b1, cmd_port_pkg::STORE_NONE}};
      repeat (4) @(posedge sys_clk_i);
      #2;
      reset_i = 1'b0;
      chk("ack after reset", 16'h0000, {15'h0000, i_cmd_port_if.in_words[0][15]});
      chk("store op after reset", 16'h0000, {12'h000, store_op_o});
      for (int i = 0; i < 11; i++)
      begin
         s0 = starts;
         v0 = valids;
         data_i[0] = 16'h5A00 + 16'(i);
         issue(rows[i].code, rows[i].ax_a, rows[i].ax_b);
         if (rows[i].op == cmd_port_pkg::STORE_NONE)
         begin
            chk("command valid count", 16'h0001, 16'(valids - v0));
            chk("command code", {8'h00, rows[i].code}, {8'h00, cmd_words_o[0][7:0]});
            chk("command axis", {14'h0000, rows[i].ax_a, rows[i].ax_b},
               {14'h0000, cmd_words_o[0][13:12]});
            chk("command data", data_i[0], cmd_words_o[1]);
         end
         else
         begin
            chk("store start count", 16'h0001, 16'(starts - s0));
            chk("store op", {12'h000, rows[i].op}, {12'h000, got_op});
            chk("store axis", {14'h0000, rows[i].ax_a, rows[i].ax_b},
               {14'h0000, got_a, got_b});
            chk("store data", (rows[i].code == 8'hF5) ? data_i[0] : 16'h0000, got_data);
         end
      end
      // Reads: four parameter words per exchange, next set on each new flag rise
      issue(8'hB0, 1'b1, 1'b0);
      for (int k = 0; k < 4; k++)
         chk("read word", 16'(k), {8'h00, resp_o[4 + k][7:0]});
      first_set = resp_o[4][15:8];
      issue(8'hB0, 1'b1, 1'b0);
      chk("next read set", {8'h00, first_set + 8'h01}, {8'h00, resp_o[4][15:8]});
      status_i[5] = 16'hC35A;
      repeat (8) @(posedge sys_clk_i);
      #2;
      chk("status resumed", status_i[5], i_cmd_port_if.in_words[5]);
      // A busy store defers the write instead of dropping it
      s0 = starts;
      store_busy_i = 1'b1;
      fork
         issue(8'hF7, 1'b0, 1'b0);
         begin
            repeat (15) @(posedge sys_clk_i);
            #2;
            chk("no start while busy", 16'h0000, 16'(starts - s0));
            store_busy_i = 1'b0;
         end
      join
      chk("deferred start", 16'h0001, 16'(starts - s0));
      chk("deferred op", {12'h000, cmd_port_pkg::STORE_SYS}, {12'h000, got_op});
      // Mid-run reset returns both ends to idle and a new read starts at set 0
      reset_i = 1'b1;
      repeat (4) @(posedge sys_clk_i);
      #2;
      reset_i = 1'b0;
      chk("ack after second reset", 16'h0000, {15'h0000, i_cmd_port_if.in_words[0][15]});
      chk("store op after second reset", 16'h0000, {12'h000, store_op_o});
      issue(8'hB0, 1'b1, 1'b0);
      chk("read set after second reset", 16'h0000, {8'h00, resp_o[4][15:8]});
      chk("read word after second reset", 16'h0001, {8'h00, resp_o[5][7:0]});
      wrap_up();
   end
endmodule // tb_top
